/* hw/pps_defs.svh */
// Purpose: named constants of the point-to-point set-point handshake
// Assumes: object indices are 16 bits, object data up to 32 bits
// Notes: profile type codes are local encodings of this block
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH

// object dictionary indices
`define PPS_IDX_CMD 16'h6040
`define PPS_IDX_STAT 16'h6041
`define PPS_IDX_TARGET 16'h607a
`define PPS_IDX_VEL 16'h6081
`define PPS_IDX_ACC 16'h6083
`define PPS_IDX_DEC 16'h6084
`define PPS_IDX_PROF 16'h6086

// command word bit positions
`define PPS_CW_NEW_SP 4
`define PPS_CW_CHG_IMM 5
`define PPS_CW_REL 6
`define PPS_CW_HALT 8

// status word bit positions
`define PPS_SW_REACHED 10
`define PPS_SW_ACK 12

// reset values
`define PPS_WORD_RST 16'h0000
`define PPS_POS_RST 32'h0000_0000

// profile type codes
`define PPS_PROF_TRAP 16'h0000
`define PPS_PROF_VEL 16'h0002
`define PPS_PROF_SCURVE 16'h0003

// quick-stop option range that reports target reached
`define PPS_QS_LO 16'h0005
`define PPS_QS_HI 16'h0008

`endif

/* hw/pps_pkg.sv */
// Purpose: shared types of the set-point handshake
// Assumes: nothing beyond pps_defs.svh
// Notes: state codes written out in binary
package pps_pkg;
    // one object dictionary word
    typedef logic [15:0] pps_word_t;
    // position, velocity and rate values
    typedef logic [31:0] pps_pos_t;
    // motion state of the handshake
    typedef enum logic [1:0] {
        PPS_ST_IDLE = 2'b00,
        PPS_ST_MOVING = 2'b01,
        PPS_ST_HALTED = 2'b10
    } pps_state_e;
endpackage

/* hw/pps_edge_det.sv */
// Purpose: edge finder on one bit of a written word
// Assumes: i_load marks a write of the word holding the bit
// Notes: edges are seen only on writes, never between them
`timescale 1ns/10ps
`default_nettype none
module pps_edge_det (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_load,
    input wire logic i_bit,
    output logic o_rise,
    output logic o_fall
);
    // last written value of the bit
    logic bit_ff;

    // hold the bit across writes
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            bit_ff <= 1'b0;
        end else if (i_load) begin
            bit_ff <= i_bit;
        end
    end

    // compare the new value against the stored one
    always_comb begin
        o_rise = i_load & i_bit & ~bit_ff;
        o_fall = i_load & ~i_bit & bit_ff;
    end
endmodule
`default_nettype wire

/* hw/pps_setpoint.sv */
// Purpose: set-point handshake of profile position mode
// Assumes: object writes and reads arrive as one-cycle strobes
// Notes: trajectory maths lives outside; this block hands it moves
// How it works
// - trigger rise copies buffer into active move
// - trigger ignored while moving, no immediate-change
// - immediate-change replaces move for trapezoid, velocity
// - S-curve discards updates made during motion
// - relative bit adds target to commanded position
// - halt bit stops motion until released
// - reached set at target, cleared on acceptance
// - quick-stop codes five to eight set reached
// - halt coming to rest sets reached
// - acknowledge set on accept, cleared on release
// - rejected triggers leave acknowledge clear
// - master releases trigger; falling edge clears acknowledge
`timescale 1ns/10ps
`default_nettype none
`include "pps_defs.svh"
module pps_setpoint (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_od_wr_en,
    input wire logic i_od_rd_en,
    input wire pps_pkg::pps_word_t i_od_index,
    input wire pps_pkg::pps_pos_t i_od_wdata,
    input wire pps_pkg::pps_pos_t i_cmd_pos,
    input wire logic i_traj_at_target,
    input wire logic i_qs_done,
    input wire pps_pkg::pps_word_t i_qs_option,
    input wire logic i_drive_at_rest,
    output pps_pkg::pps_pos_t o_od_rdata,
    output logic o_od_rvalid,
    output pps_pkg::pps_word_t o_status_word,
    output pps_pkg::pps_pos_t o_act_target,
    output pps_pkg::pps_pos_t o_act_vel,
    output pps_pkg::pps_pos_t o_act_acc,
    output pps_pkg::pps_pos_t o_act_dec,
    output pps_pkg::pps_word_t o_act_profile,
    output logic o_move_start,
    output logic o_halt_req
);
    import pps_pkg::*;

    pps_word_t cmd_ff; // stored command word
    pps_word_t status_ff; // status word bits
    pps_pos_t buf_target_ff; // next-move target
    pps_pos_t buf_vel_ff; // next-move velocity
    pps_pos_t buf_acc_ff; // next-move acceleration
    pps_pos_t buf_dec_ff; // next-move deceleration
    pps_word_t buf_prof_ff; // next-move profile type
    pps_pos_t act_target_ff; // active destination
    pps_pos_t act_vel_ff; // active velocity
    pps_pos_t act_acc_ff; // active acceleration
    pps_pos_t act_dec_ff; // active deceleration
    pps_word_t act_prof_ff; // active profile type
    logic start_ff; // one-cycle move start
    logic halt_ff; // halt request level
    pps_pos_t rdata_ff; // read answer
    logic rvalid_ff; // read answer strobe
    pps_state_e state_ff; // motion state
    pps_state_e nxt_state; // next motion state
    logic cmd_wr; // command word written
    logic trig_rise; // trigger bit rose
    logic trig_fall; // trigger bit fell
    logic halt_fall; // halt bit released
    logic busy; // a move in progress
    logic scurve; // buffered profile is S-curve
    logic accept; // trigger taken
    logic qs_hit; // quick stop ends with reached
    logic rest_hit; // halt reached standstill
    logic reach_set; // any reached event
    pps_pos_t rel_sum; // relative destination
    pps_pos_t nxt_target; // destination chosen at accept

    assign o_status_word = status_ff;
    assign o_act_target = act_target_ff;
    assign o_act_vel = act_vel_ff;
    assign o_act_acc = act_acc_ff;
    assign o_act_dec = act_dec_ff;
    assign o_act_profile = act_prof_ff;
    assign o_move_start = start_ff;
    assign o_halt_req = halt_ff;
    assign o_od_rdata = rdata_ff;
    assign o_od_rvalid = rvalid_ff;

    // write decode of the command word
    assign cmd_wr = i_od_wr_en && (i_od_index == `PPS_IDX_CMD);

    pps_edge_det u_trig_edge (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_load(cmd_wr),
        .i_bit(i_od_wdata[`PPS_CW_NEW_SP]),
        .o_rise(trig_rise),
        .o_fall(trig_fall)
    );

    pps_edge_det u_halt_edge (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_load(cmd_wr),
        .i_bit(i_od_wdata[`PPS_CW_HALT]),
        .o_rise(),
        .o_fall(halt_fall)
    );

    // trigger qualification and destination choice
    always_comb begin
        busy = (state_ff != PPS_ST_IDLE);
        scurve = (buf_prof_ff == `PPS_PROF_SCURVE);
        accept = trig_rise && (!busy || (i_od_wdata[`PPS_CW_CHG_IMM] && !scurve));
        rel_sum = i_cmd_pos + buf_target_ff;
        nxt_target = i_od_wdata[`PPS_CW_REL] ? rel_sum : buf_target_ff;
        qs_hit = i_qs_done && (i_qs_option >= `PPS_QS_LO) && (i_qs_option <= `PPS_QS_HI);
        rest_hit = (state_ff == PPS_ST_HALTED) && i_drive_at_rest;
        reach_set = i_traj_at_target || qs_hit || rest_hit;
    end

    // command word store
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            cmd_ff <= `PPS_WORD_RST;
        end else if (cmd_wr) begin
            cmd_ff <= i_od_wdata[15:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            buf_target_ff <= `PPS_POS_RST;
            buf_vel_ff <= `PPS_POS_RST;
            buf_acc_ff <= `PPS_POS_RST;
            buf_dec_ff <= `PPS_POS_RST;
            buf_prof_ff <= `PPS_PROF_TRAP;
        end else if (i_od_wr_en) begin
            case (i_od_index)
                `PPS_IDX_TARGET: begin
                    buf_target_ff <= i_od_wdata;
                end
                `PPS_IDX_VEL: begin
                    buf_vel_ff <= i_od_wdata;
                end
                `PPS_IDX_ACC: begin
                    buf_acc_ff <= i_od_wdata;
                end
                `PPS_IDX_DEC: begin
                    buf_dec_ff <= i_od_wdata;
                end
                `PPS_IDX_PROF: begin
                    buf_prof_ff <= i_od_wdata[15:0];
                end
                default: begin
                    // other indices leave the buffer alone
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            act_target_ff <= `PPS_POS_RST;
            act_vel_ff <= `PPS_POS_RST;
            act_acc_ff <= `PPS_POS_RST;
            act_dec_ff <= `PPS_POS_RST;
            act_prof_ff <= `PPS_PROF_TRAP;
            start_ff <= 1'b0;
        end else begin
            start_ff <= accept;
            if (accept) begin
                act_target_ff <= nxt_target;
                act_vel_ff <= buf_vel_ff;
                act_acc_ff <= buf_acc_ff;
                act_dec_ff <= buf_dec_ff;
                act_prof_ff <= buf_prof_ff;
            end
        end
    end

    // halt request follows the halt bit
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            halt_ff <= 1'b0;
        end else if (cmd_wr) begin
            halt_ff <= i_od_wdata[`PPS_CW_HALT];
        end
    end

    // motion state: idle, moving, halted
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PPS_ST_IDLE: begin
                if (accept) begin
                    nxt_state = PPS_ST_MOVING;
                end
            end
            PPS_ST_MOVING: begin
                if (qs_hit) begin
                    nxt_state = PPS_ST_IDLE;
                end else if (halt_ff) begin
                    nxt_state = PPS_ST_HALTED;
                end else if (i_traj_at_target && !accept) begin
                    nxt_state = PPS_ST_IDLE;
                end
            end
            PPS_ST_HALTED: begin
                if (qs_hit) begin
                    nxt_state = PPS_ST_IDLE;
                end else if (halt_fall) begin
                    nxt_state = PPS_ST_MOVING;
                end
            end
            default: begin
                nxt_state = PPS_ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            state_ff <= PPS_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // status word: reached and acknowledge
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            status_ff <= `PPS_WORD_RST;
        end else begin
            if (reach_set) begin
                status_ff[`PPS_SW_REACHED] <= 1'b1;
            end else if (accept) begin
                status_ff[`PPS_SW_REACHED] <= 1'b0;
            end
            if (accept) begin
                status_ff[`PPS_SW_ACK] <= 1'b1;
            end else if (trig_fall) begin
                status_ff[`PPS_SW_ACK] <= 1'b0;
            end
        end
    end

    // object reads answer one cycle later
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            rdata_ff <= `PPS_POS_RST;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= i_od_rd_en;
            case (i_od_index)
                `PPS_IDX_CMD: rdata_ff <= {16'h0000, cmd_ff};
                `PPS_IDX_STAT: rdata_ff <= {16'h0000, status_ff};
                `PPS_IDX_TARGET: rdata_ff <= buf_target_ff;
                `PPS_IDX_VEL: rdata_ff <= buf_vel_ff;
                `PPS_IDX_ACC: rdata_ff <= buf_acc_ff;
                `PPS_IDX_DEC: rdata_ff <= buf_dec_ff;
                `PPS_IDX_PROF: rdata_ff <= {16'h0000, buf_prof_ff};
                default: rdata_ff <= `PPS_POS_RST;
            endcase
        end
    end

    property p_copy;
        @(posedge i_core_clk) disable iff (!i_resetn)
        accept |=> (o_act_vel == $past(buf_vel_ff)) && o_move_start;
    endproperty
    a_copy: assert property (p_copy) else $error("buffer not copied");

    property p_ignore;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (trig_rise && busy && !i_od_wdata[`PPS_CW_CHG_IMM]) |=> !o_move_start;
    endproperty
    a_ignore: assert property (p_ignore) else $error("trigger not ignored");

    property p_replace;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (trig_rise && busy && i_od_wdata[`PPS_CW_CHG_IMM] && !scurve) |=> o_move_start;
    endproperty
    a_replace: assert property (p_replace) else $error("no immediate update");

    property p_scurve;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (trig_rise && busy && scurve) |=> $stable(o_act_target) && !o_move_start;
    endproperty
    a_scurve: assert property (p_scurve) else $error("s-curve move changed");

    property p_rel;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (accept && i_od_wdata[`PPS_CW_REL]) |=> (o_act_target == $past(rel_sum));
    endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");

    property p_halt;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (o_halt_req && state_ff == PPS_ST_HALTED && !halt_fall && !qs_hit)
            |=> (state_ff == PPS_ST_HALTED);
    endproperty
    a_halt: assert property (p_halt) else $error("halt resumed early");

    property p_reach;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_traj_at_target || qs_hit || rest_hit) |=> o_status_word[`PPS_SW_REACHED];
    endproperty
    a_reach: assert property (p_reach) else $error("reached not set");

    property p_reach_clr;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (accept && !reach_set) |=> !o_status_word[`PPS_SW_REACHED];
    endproperty
    a_reach_clr: assert property (p_reach_clr) else $error("reached not cleared");

    property p_ack;
        @(posedge i_core_clk) disable iff (!i_resetn)
        accept |=> o_status_word[`PPS_SW_ACK];
    endproperty
    a_ack: assert property (p_ack) else $error("ack not set");

    property p_reject;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (trig_rise && !accept && !o_status_word[`PPS_SW_ACK])
            |=> !o_status_word[`PPS_SW_ACK];
    endproperty
    a_reject: assert property (p_reject) else $error("ack on rejected edge");

    property p_ack_clr;
        @(posedge i_core_clk) disable iff (!i_resetn)
        trig_fall |=> !o_status_word[`PPS_SW_ACK];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("ack not cleared");
endmodule
`default_nettype wire

/* sim/pps_master.sv */
// Purpose: network master model writing command and move objects
// Assumes: one object a call, strobe held one cycle, changes at rising edges
// Notes: released index and data lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
`include "pps_defs.svh"
module pps_master (
    input wire logic i_core_clk,
    output logic o_wr_en,
    output logic o_rd_en,
    output pps_pkg::pps_word_t o_index,
    output pps_pkg::pps_pos_t o_wdata
);
    import pps_pkg::*;
    // idle bus at time zero
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_index = 16'h0000;
        o_wdata = 32'h0000_0000;
    end
    // one write, taken at the second edge
    task automatic wr(input pps_word_t idx, input pps_pos_t data);
        @(posedge i_core_clk);
        o_wr_en <= 1'b1;
        o_index <= idx;
        o_wdata <= data;
        @(posedge i_core_clk);
        o_wr_en <= 1'b0;
        o_index <= ~idx;
        o_wdata <= ~data;
    endtask
    // one read, answer stands the cycle after return
    task automatic rd(input pps_word_t idx);
        @(posedge i_core_clk);
        o_rd_en <= 1'b1;
        o_index <= idx;
        @(posedge i_core_clk);
        o_rd_en <= 1'b0;
        o_index <= ~idx;
    endtask
    task automatic load(input pps_word_t cw, input pps_pos_t tgt, input pps_word_t prof);
        wr(`PPS_IDX_CMD, {16'h0000, cw & 16'hffef});
        wr(`PPS_IDX_TARGET, tgt);
        wr(`PPS_IDX_VEL, tgt ^ 32'h0000_0011);
        wr(`PPS_IDX_ACC, tgt ^ 32'h0000_0022);
        wr(`PPS_IDX_DEC, tgt ^ 32'h0000_0033);
        wr(`PPS_IDX_PROF, {16'h0000, prof});
    endtask
    task automatic trig(input pps_word_t cw);
        wr(`PPS_IDX_CMD, {16'h0000, cw | 16'h0010});
    endtask
    task automatic rel(input pps_word_t cw);
        wr(`PPS_IDX_CMD, {16'h0000, cw & 16'hffef});
    endtask
endmodule
`default_nettype wire

/* sim/point_to_point_setpoint_handshake_bench.sv */
// Purpose: self-checking bench of the set-point handshake
// Assumes: answers stand from the taking edge, checked 1 ns later
// Notes: each scenario judges its own outcome before returning
`timescale 1ns/10ps
`default_nettype none
`include "pps_defs.svh"
module point_to_point_setpoint_handshake_bench;
    import pps_pkg::*;
    // clock, reset, inputs and outputs of the block under test
    logic i_core_clk, i_resetn, i_od_wr_en, i_od_rd_en;
    logic i_traj_at_target, i_qs_done, i_drive_at_rest;
    pps_word_t i_od_index, i_qs_option, o_status_word, o_act_profile;
    pps_pos_t i_od_wdata, i_cmd_pos, o_od_rdata;
    pps_pos_t o_act_target, o_act_vel, o_act_acc, o_act_dec;
    logic o_od_rvalid, o_move_start, o_halt_req;
    int num_errors = 0;
    int n_checks = 0;
    // master model on the object bus
    pps_master u_master (
        .i_core_clk,
        .o_wr_en(i_od_wr_en),
        .o_rd_en(i_od_rd_en),
        .o_index(i_od_index),
        .o_wdata(i_od_wdata)
    );
    // block under test
    pps_setpoint u_dut (
        .i_core_clk,
        .i_resetn,
        .i_od_wr_en,
        .i_od_rd_en,
        .i_od_index,
        .i_od_wdata,
        .i_cmd_pos,
        .i_traj_at_target,
        .i_qs_done,
        .i_qs_option,
        .i_drive_at_rest,
        .o_od_rdata,
        .o_od_rvalid,
        .o_status_word,
        .o_act_target,
        .o_act_vel,
        .o_act_acc,
        .o_act_dec,
        .o_act_profile,
        .o_move_start,
        .o_halt_req
    );
    // 200 mhz clock
    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    // compare and count
    task automatic chk(input pps_pos_t seen, input pps_pos_t exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // counts, verdict and end of run
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // accepted trigger, then release
    task automatic accept(input pps_word_t cw, input pps_pos_t tgt, input pps_word_t prof,
                          input pps_pos_t exp_tgt);
        u_master.load(cw, tgt, prof);
        u_master.trig(cw);
        #1;
        chk(o_move_start, 1);
        chk(o_status_word, 32'h0000_1000);
        chk(o_act_target, exp_tgt);
        chk(o_act_dec, tgt ^ 32'h0000_0033);
        chk(o_act_vel, tgt ^ 32'h0000_0011);
        chk(o_act_acc, tgt ^ 32'h0000_0022);
        chk(o_act_profile, prof);
        u_master.rel(cw);
        #1;
        chk(o_status_word[12], 0);
    endtask
    // refused trigger leaves move and acknowledge alone
    task automatic reject(input pps_word_t cw, input pps_pos_t tgt, input pps_word_t prof,
                          input pps_pos_t old_tgt);
        u_master.load(cw, tgt, prof);
        u_master.trig(cw);
        #1;
        chk(o_move_start, 0);
        chk(o_status_word[12], 0);
        chk(o_act_target, old_tgt);
        u_master.rel(cw);
    endtask
    // generator arrives at target
    task automatic finish_move();
        @(posedge i_core_clk);
        i_traj_at_target <= 1'b1;
        @(posedge i_core_clk);
        i_traj_at_target <= 1'b0;
        #1;
        chk(o_status_word[10], 1);
    endtask
    // reset values and object bus refusals
    task automatic t_reset();
        chk(o_status_word, 0);
        chk(o_act_profile, `PPS_PROF_TRAP);
        chk(o_halt_req, 0);
        u_master.wr(`PPS_IDX_STAT, 32'h0000_ffff);
        u_master.rd(`PPS_IDX_STAT);
        #1;
        chk(o_od_rvalid, 1);
        chk(o_od_rdata, 0);
        u_master.rd(16'h1234);
        #1;
        chk(o_od_rvalid, 1);
        chk(o_od_rdata, 0);
    endtask
    // discrete series, absolute then relative
    task automatic t_series();
        for (int i = 1; i <= 3; i++) begin
            accept(16'h0000, 32'h100 * i, `PPS_PROF_TRAP, 32'h100 * i);
            finish_move();
        end
        @(posedge i_core_clk);
        i_cmd_pos <= 32'h0000_1000;
        accept(16'h0040, 32'h0000_0020, `PPS_PROF_TRAP, 32'h0000_1020);
        finish_move();
        // readback: reached only, released command, buffered target
        u_master.rd(`PPS_IDX_STAT);
        #1;
        chk(o_od_rvalid, 1);
        chk(o_od_rdata, 32'h0000_0400);
        u_master.rd(`PPS_IDX_CMD);
        #1;
        chk(o_od_rdata, 32'h0000_0040);
        u_master.rd(`PPS_IDX_TARGET);
        #1;
        chk(o_od_rdata, 32'h0000_0020);
    endtask
    // trigger during motion without immediate change
    task automatic t_ignore();
        accept(16'h0000, 32'h0000_0300, `PPS_PROF_TRAP, 32'h0000_0300);
        reject(16'h0000, 32'h0000_0400, `PPS_PROF_TRAP, 32'h0000_0300);
        finish_move();
    endtask
    // immediate replacement for trapezoid and velocity
    task automatic t_immediate();
        pps_word_t profs[2];
        profs = '{`PPS_PROF_TRAP, `PPS_PROF_VEL};
        foreach (profs[k]) begin
            accept(16'h0000, 32'h0000_0500, profs[k], 32'h0000_0500);
            accept(16'h0020, 32'h0000_0600, profs[k], 32'h0000_0600);
            finish_move();
        end
    endtask
    // s-curve discards an update in motion
    task automatic t_scurve();
        accept(16'h0000, 32'h0000_0700, `PPS_PROF_SCURVE, 32'h0000_0700);
        reject(16'h0020, 32'h0000_0800, `PPS_PROF_SCURVE, 32'h0000_0700);
        finish_move();
    endtask
    // halt, rest sets reached, release resumes
    task automatic t_halt();
        accept(16'h0000, 32'h0000_0900, `PPS_PROF_TRAP, 32'h0000_0900);
        u_master.wr(`PPS_IDX_CMD, 32'h0000_0100);
        #1;
        chk(o_halt_req, 1);
        @(posedge i_core_clk);
        i_drive_at_rest <= 1'b1;
        @(posedge i_core_clk);
        i_drive_at_rest <= 1'b0;
        #1;
        chk(o_status_word[10], 1);
        u_master.wr(`PPS_IDX_CMD, 32'h0000_0000);
        #1;
        chk(o_halt_req, 0);
        finish_move();
    endtask
    // quick-stop option codes around the five-to-eight range
    task automatic t_qstop();
        for (int c = 4; c <= 9; c++) begin
            accept(16'h0000, 32'h0000_0a00 + c, `PPS_PROF_TRAP, 32'h0000_0a00 + c);
            @(posedge i_core_clk);
            i_qs_option <= 16'(c);
            i_qs_done <= 1'b1;
            @(posedge i_core_clk);
            i_qs_done <= 1'b0;
            #1;
            chk(o_status_word[10], (c >= 5 && c <= 8));
            if (c < 5 || c > 8) begin
                finish_move();
            end
        end
    endtask
    // main sequence
    initial begin
        i_resetn = 1'b0;
        i_cmd_pos = 32'h0000_0000;
        i_traj_at_target = 1'b0;
        i_qs_done = 1'b0;
        i_qs_option = 16'h0000;
        i_drive_at_rest = 1'b0;
        repeat (8) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        @(posedge i_core_clk);
        #1;
        t_reset();
        t_series();
        t_ignore();
        t_immediate();
        t_scurve();
        t_halt();
        t_qstop();
        close_out();
    end
endmodule
`default_nettype wire
